// ---- hdl/three_bit_shared_io_port.sv ----
/*
  Three-bit shared general-purpose I/O port behind an AXI4-Lite slave:
  direction and data registers, pin drive, read-back mixing, standby handling
  and the pin sharing with the serial unit and external interrupt four.
  Assumes pin inputs and serial controls synchronous to aclk, and standby
  levels driven by the system controller.
*/
//
// Contract
// - Eight-bit data register; bits 4, 2, 0 map to the three pins.
// - Direction bit 1 drives data bit out; direction bit 0 makes input.
// - Direction register is write-only, eight bits; reads return all ones.
// - Direction register loads C0 on reset and on hardware standby.
// - Software standby holds direction and keeps output pins driving.
// - Read gives data bit for outputs and pin level for inputs.
// - Data bits 7 and 6 ignore writes and read as one.
// - Data bits 5, 3, 1 store values but touch no pin.
// - Bits 5, 3, 1 read stored value if direction one, else one.
// - Data register is C0 on reset and hardware standby, held in software standby.
// - Direction at index FFD0, data at FFD2, sixteen index bits (address bits 17 to 2) decoded.
// - Pins also carry serial transmit, receive, clock and interrupt four.
module three_bit_shared_io_port
  import gpio_port_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 s_axi_awvalid,
  output      logic                 s_axi_awready,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_wvalid,
  output      logic                 s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output      logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output      logic [1:0]           s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output      logic                 s_axi_arready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  output      logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output      logic [31:0]          s_axi_rdata,
  output      logic [1:0]           s_axi_rresp,
  input  wire logic                 sw_standby,
  input  wire logic                 hw_standby,
  input  wire logic [PIN_COUNT-1:0] pin_in,
  output      logic [PIN_COUNT-1:0] pin_out,
  output      logic [PIN_COUNT-1:0] pin_oe,
  input  wire serial_ctrl_t         serial_ctrl,
  output      serial_return_t       serial_ret,
  output      logic                 external_interrupt_line_four_n
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  wr_state_t            wr_state_q,  wr_state_d;
  rd_state_t            rd_state_q,  rd_state_d;
  logic                 awready_q,   awready_d;
  logic                 wready_q,    wready_d;
  logic                 bvalid_q,    bvalid_d;
  logic [1:0]           bresp_q,     bresp_d;
  logic                 aw_have_q,   aw_have_d;
  logic                 w_have_q,    w_have_d;
  logic [INDEX_W-1:0]   aw_index_q,  aw_index_d;
  logic [7:0]           wbyte_q,     wbyte_d;
  logic                 wlane_q,     wlane_d;
  logic                 commit;
  logic                 arready_q,   arready_d;
  logic                 rvalid_q,    rvalid_d;
  logic [31:0]          rdata_q,     rdata_d;
  logic [1:0]           rresp_q,     rresp_d;
  logic [INDEX_W-1:0]   ar_index;
  logic [7:0]           dir_q,       dir_d;
  logic [7:0]           data_q,      data_d;
  logic [PIN_COUNT-1:0] level_q,     level_d;
  logic [7:0]           level_wide;
  logic [7:0]           read_byte;
  logic [PIN_COUNT-1:0] gp_dir;
  logic [PIN_COUNT-1:0] gp_data;
  logic [PIN_COUNT-1:0] alt_en;
  logic [PIN_COUNT-1:0] alt_oe;
  logic [PIN_COUNT-1:0] alt_out;
  logic [PIN_COUNT-1:0] cell_out;
  logic [PIN_COUNT-1:0] cell_oe;
  logic [PIN_COUNT-1:0] pin_out_q,   pin_out_d;
  logic [PIN_COUNT-1:0] pin_oe_q,    pin_oe_d;
  serial_return_t       serial_ret_q, serial_ret_d;
  logic                 int_four_n_q, int_four_n_d;

  // Index bits only; upper address bits and byte offset are not decoded
  assign ar_index = s_axi_araddr[INDEX_LSB +: INDEX_W];

  // ==========================================================================
  // Write channel
  // ==========================================================================
  always_comb begin
    wr_state_d = wr_state_q;
    aw_have_d  = aw_have_q;
    w_have_d   = w_have_q;
    aw_index_d = aw_index_q;
    wbyte_d    = wbyte_q;
    wlane_d    = wlane_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    commit     = 1'b0;
    case (wr_state_q)
      WR_COLLECT: begin
        if (s_axi_awvalid && awready_q) begin
          aw_have_d  = 1'b1;
          aw_index_d = s_axi_awaddr[INDEX_LSB +: INDEX_W];
        end
        if (s_axi_wvalid && wready_q) begin
          w_have_d = 1'b1;
          wbyte_d  = s_axi_wdata[7:0];
          wlane_d  = s_axi_wstrb[0];
        end
        if (aw_have_d && w_have_d) begin
          commit     = 1'b1;
          aw_have_d  = 1'b0;
          w_have_d   = 1'b0;
          bvalid_d   = 1'b1;
          wr_state_d = WR_RESP;
          if ((aw_index_d == DIR_INDEX) || (aw_index_d == DATA_INDEX)) begin
            bresp_d = RESP_OKAY;
          end else begin
            bresp_d = RESP_DECERR;
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_d   = 1'b0;
          wr_state_d = WR_COLLECT;
        end
      end
      default: begin
        wr_state_d = WR_COLLECT;
        bvalid_d   = 1'b0;
      end
    endcase
    awready_d = (wr_state_d == WR_COLLECT) && !aw_have_d;
    wready_d  = (wr_state_d == WR_COLLECT) && !w_have_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= WR_COLLECT;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      aw_index_q <= '0;
      wbyte_q    <= 8'h00;
      wlane_q    <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
    end else begin
      wr_state_q <= wr_state_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      aw_index_q <= aw_index_d;
      wbyte_q    <= wbyte_d;
      wlane_q    <= wlane_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
    end
  end

  // ==========================================================================
  // Port registers
  // ==========================================================================
  // The processor is halted in software standby, so a write there is dropped
  always_comb begin
    dir_d  = dir_q;
    data_d = data_q;
    if (hw_standby) begin
      dir_d  = DIR_RESET;
      data_d = DATA_RESET;
    end else if (commit && wlane_d && !sw_standby) begin
      if (aw_index_d == DIR_INDEX) begin
        dir_d = wbyte_d;
      end
      if (aw_index_d == DATA_INDEX) begin
        data_d = wbyte_d | FIXED_ONE_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q  <= DIR_RESET;
      data_q <= DATA_RESET;
    end else begin
      dir_q  <= dir_d;
      data_q <= data_d;
    end
  end

  // ==========================================================================
  // Read-back mixing
  // ==========================================================================
  always_comb begin
    level_wide           = 8'h00;
    level_wide[BIT_FOUR] = level_q[SLOT_FOUR];
    level_wide[BIT_TWO]  = level_q[SLOT_TWO];
    level_wide[BIT_ZERO] = level_q[SLOT_ZERO];
    read_byte = FIXED_ONE_MASK
              | (dir_q & data_q)
              | (~dir_q & PIN_MASK & level_wide)
              | (~dir_q & SPARE_MASK);
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  always_comb begin
    rd_state_d = rd_state_q;
    arready_d  = arready_q;
    rvalid_d   = rvalid_q;
    rdata_d    = rdata_q;
    rresp_d    = rresp_q;
    case (rd_state_q)
      RD_IDLE: begin
        arready_d = 1'b1;
        if (s_axi_arvalid && arready_q) begin
          arready_d  = 1'b0;
          rvalid_d   = 1'b1;
          rd_state_d = RD_DATA;
          rresp_d    = RESP_OKAY;
          if (ar_index == DIR_INDEX) begin
            rdata_d = {24'h00_0000, DIR_READ_VALUE};
          end else if (ar_index == DATA_INDEX) begin
            rdata_d = {24'h00_0000, read_byte};
          end else begin
            rdata_d = WORD_ZERO;
            rresp_d = RESP_DECERR;
          end
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          rvalid_d   = 1'b0;
          arready_d  = 1'b1;
          rd_state_d = RD_IDLE;
        end
      end
      default: begin
        rd_state_d = RD_IDLE;
        rvalid_d   = 1'b0;
        arready_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= RD_IDLE;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= WORD_ZERO;
      rresp_q    <= RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
    end
  end

  // ==========================================================================
  // Pin function select
  // ==========================================================================
  always_comb begin
    gp_dir  = {dir_q[BIT_FOUR],  dir_q[BIT_TWO],  dir_q[BIT_ZERO]};
    gp_data = {data_q[BIT_FOUR], data_q[BIT_TWO], data_q[BIT_ZERO]};
    // Clock input request wins over clock output on the shared clock pin
    alt_en[SLOT_FOUR]  = serial_ctrl.clk_drive_enable | serial_ctrl.clk_input_enable;
    alt_oe[SLOT_FOUR]  = !serial_ctrl.clk_input_enable;
    alt_out[SLOT_FOUR] = serial_ctrl.clk_out;
    alt_en[SLOT_TWO]   = serial_ctrl.rx_enable;
    alt_oe[SLOT_TWO]   = 1'b0;
    alt_out[SLOT_TWO]  = 1'b0;
    alt_en[SLOT_ZERO]  = serial_ctrl.tx_enable;
    alt_oe[SLOT_ZERO]  = 1'b1;
    alt_out[SLOT_ZERO] = serial_ctrl.tx_data;
  end

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_cell
    shared_pin_cell #(
      .HAS_ALT (1'b1)
    ) u_cell (
      .gp_dir  (gp_dir[i]),
      .gp_data (gp_data[i]),
      .alt_en  (alt_en[i]),
      .alt_oe  (alt_oe[i]),
      .alt_out (alt_out[i]),
      .pad_out (cell_out[i]),
      .pad_oe  (cell_oe[i])
    );
  end

  // ==========================================================================
  // Pin drive and sampling
  // ==========================================================================
  // Pins float in hardware standby; software standby freezes the drive
  always_comb begin
    level_d = pin_in;
    if (hw_standby) begin
      pin_out_d = 3'h0;
      pin_oe_d  = 3'h0;
    end else if (sw_standby) begin
      pin_out_d = pin_out_q;
      pin_oe_d  = pin_oe_q;
    end else begin
      pin_out_d = cell_out;
      pin_oe_d  = cell_oe;
    end
    serial_ret_d.rx_data = pin_in[SLOT_TWO];
    serial_ret_d.clk_in  = pin_in[SLOT_FOUR];
    int_four_n_d         = pin_in[SLOT_FOUR];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q      <= 3'h0;
      pin_out_q    <= 3'h0;
      pin_oe_q     <= 3'h0;
      serial_ret_q <= '0;
      int_four_n_q <= 1'b1;
    end else begin
      level_q      <= level_d;
      pin_out_q    <= pin_out_d;
      pin_oe_q     <= pin_oe_d;
      serial_ret_q <= serial_ret_d;
      int_four_n_q <= int_four_n_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign s_axi_awready                  = awready_q;
  assign s_axi_wready                   = wready_q;
  assign s_axi_bvalid                   = bvalid_q;
  assign s_axi_bresp                    = bresp_q;
  assign s_axi_arready                  = arready_q;
  assign s_axi_rvalid                   = rvalid_q;
  assign s_axi_rdata                    = rdata_q;
  assign s_axi_rresp                    = rresp_q;
  assign pin_out                        = pin_out_q;
  assign pin_oe                         = pin_oe_q;
  assign serial_ret                     = serial_ret_q;
  assign external_interrupt_line_four_n = int_four_n_q;

endmodule : three_bit_shared_io_port

// ---- hdl/gpio_port_pkg.sv ----
/*
  Shared constants and carrier types for the three-bit shared I/O port:
  register indices, reset values, bit masks, bus response codes and the
  packed structs that travel between the port and the serial unit.
  Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
*/
package gpio_port_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  // Printed offsets are indices; the byte address is four times the index.
  localparam logic [15:0] DIR_INDEX      = 16'hFFD0;
  localparam logic [15:0] DATA_INDEX     = 16'hFFD2;
  localparam int          INDEX_LSB      = 2;
  localparam int          INDEX_W        = 16;

  // ==========================================================================
  // Reset values and field layout
  // ==========================================================================
  localparam logic [7:0]  DIR_RESET      = 8'hC0;
  localparam logic [7:0]  DATA_RESET     = 8'hC0;
  localparam logic [7:0]  DIR_READ_VALUE = 8'hFF;
  localparam logic [7:0]  FIXED_ONE_MASK = 8'hC0;
  localparam logic [7:0]  PIN_MASK       = 8'h15;
  localparam logic [7:0]  SPARE_MASK     = 8'h2A;
  localparam int          BIT_FOUR       = 4;
  localparam int          BIT_TWO        = 2;
  localparam int          BIT_ZERO       = 0;
  localparam int          PIN_COUNT      = 3;

  // Pin vector slots: [2] bit four, [1] bit two, [0] bit zero
  localparam int          SLOT_FOUR      = 2;
  localparam int          SLOT_TWO       = 1;
  localparam int          SLOT_ZERO      = 0;

  // ==========================================================================
  // Bus responses
  // ==========================================================================
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_DECERR    = 2'b11;
  localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

  // ==========================================================================
  // State machines
  // ==========================================================================
  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP    = 1'b1
  } wr_state_t;

  typedef enum logic [0:0] {
    RD_IDLE    = 1'b0,
    RD_DATA    = 1'b1
  } rd_state_t;

  // ==========================================================================
  // Serial unit carriers
  // ==========================================================================
  typedef struct packed {
    logic tx_data;
    logic tx_enable;
    logic rx_enable;
    logic clk_out;
    logic clk_drive_enable;
    logic clk_input_enable;
  } serial_ctrl_t;

  typedef struct packed {
    logic rx_data;
    logic clk_in;
  } serial_return_t;

endpackage : gpio_port_pkg

// ---- hdl/shared_pin_cell.sv ----
/*
  One shared pin's function select: the alternate function, when enabled,
  takes the pin over from the general-purpose direction and data setting.
  Purely combinational; the caller registers the result.
*/
module shared_pin_cell #(
  parameter bit HAS_ALT = 1'b1
) (
  input  wire logic gp_dir,
  input  wire logic gp_data,
  input  wire logic alt_en,
  input  wire logic alt_oe,
  input  wire logic alt_out,
  output      logic pad_out,
  output      logic pad_oe
);

  // ==========================================================================
  // Function select
  // ==========================================================================
  always_comb begin
    if (HAS_ALT && alt_en) begin
      pad_out = alt_out;
      pad_oe  = alt_oe;
    end else begin
      pad_out = gp_data;
      pad_oe  = gp_dir;
    end
  end

endmodule : shared_pin_cell

// ---- dv/three_bit_shared_io_port_props.sv ----
/*
  Checker for the three-bit shared I/O port, watching its top-level ports.
  Assumes a single clock domain and synchronous active-low reset.
*/
module three_bit_shared_io_port_props
  import gpio_port_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [ADDR_W-1:0]    s_axi_araddr,
  input wire logic                 s_axi_rvalid,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 sw_standby,
  input wire logic                 hw_standby,
  input wire logic [PIN_COUNT-1:0] pin_in,
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  input wire serial_ctrl_t         serial_ctrl,
  input wire serial_return_t       serial_ret,
  input wire logic                 external_interrupt_line_four_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Read target tracking
  // ==========================================================================
  logic dir_rd_q, dir_rd_d, map_rd_q, map_rd_d;
  always_comb begin
    dir_rd_d = dir_rd_q;
    map_rd_d = map_rd_q;
    if (s_axi_arvalid && s_axi_arready) begin
      dir_rd_d = s_axi_araddr[17:2] == DIR_INDEX;
      map_rd_d = dir_rd_d || (s_axi_araddr[17:2] == DATA_INDEX);
    end
  end
  always_ff @(posedge aclk) begin
    dir_rd_q <= dir_rd_d;
    map_rd_q <= map_rd_d;
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence alt_free;
    !sw_standby && !hw_standby;
  endsequence

  chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  chk_dir_ones: assert property (s_axi_rvalid && dir_rd_q |-> s_axi_rdata == 32'h0000_00FF)
    else $error("direction read not all ones");
  chk_fixed_ones: assert property (s_axi_rvalid && map_rd_q && !dir_rd_q |-> s_axi_rdata[31:6] == 26'h3)
    else $error("data bits 7 and 6 not one");
  chk_unmapped_read: assert property (s_axi_rvalid && !map_rd_q |-> s_axi_rresp == RESP_DECERR && s_axi_rdata == WORD_ZERO)
    else $error("unmapped read not refused");
  chk_hw_release: assert property (hw_standby [*3] |-> pin_oe == 3'h0 && pin_out == 3'h0)
    else $error("pins driven in hardware standby");
  chk_sw_freeze: assert property ((sw_standby && !hw_standby) [*3] |-> $stable(pin_oe) && $stable(pin_out))
    else $error("pin drive moved in software standby");
  chk_tx_override: assert property (alt_free ##0 serial_ctrl.tx_enable |=>
    pin_oe[SLOT_ZERO] && pin_out[SLOT_ZERO] == $past(serial_ctrl.tx_data))
    else $error("transmit does not own bit zero pin");
  chk_rx_override: assert property (alt_free ##0 serial_ctrl.rx_enable |=> !pin_oe[SLOT_TWO])
    else $error("receive pin still driven");
  chk_clk_input: assert property (alt_free ##0 serial_ctrl.clk_input_enable |=> !pin_oe[SLOT_FOUR])
    else $error("clock input pin still driven");
  chk_irq_follow: assert property ($past(aresetn) |-> external_interrupt_line_four_n == $past(pin_in[SLOT_FOUR]))
    else $error("interrupt line does not follow pin");
  chk_rx_return: assert property ($past(aresetn) |->
    serial_ret == {$past(pin_in[SLOT_TWO]), $past(pin_in[SLOT_FOUR])})
    else $error("serial return does not follow pins");
endmodule : three_bit_shared_io_port_props

bind three_bit_shared_io_port three_bit_shared_io_port_props #(.ADDR_W(ADDR_W)) props_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .sw_standby(sw_standby), .hw_standby(hw_standby), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .serial_ctrl(serial_ctrl), .serial_ret(serial_ret),
  .external_interrupt_line_four_n(external_interrupt_line_four_n));

// ---- dv/board_pin_model.sv ----
/*
  Board side of the three shared pins: resolves each pin's level.
  Assumes the bench sets the level that the board puts on released pins.
*/
module board_pin_model
  import gpio_port_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] pin_out,
  input  wire logic [PIN_COUNT-1:0] pin_oe,
  input  wire logic [PIN_COUNT-1:0] ext_level,
  output      logic [PIN_COUNT-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin reads back its own level; a released one follows the board
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
endmodule : board_pin_model

// ---- dv/three_bit_shared_io_port_test.sv ----
/*
  Self-checking bench for the three-bit shared I/O port.
  Assumes the design package and the board pin model are compiled first.
*/
module three_bit_shared_io_port_test
  import gpio_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] A_DIR   = {14'h0, DIR_INDEX, 2'b00};
  localparam logic [31:0] A_DATA  = {14'h0, DATA_INDEX, 2'b00};
  localparam logic [31:0] A_HOLE  = {14'h0, 16'hFFD1, 2'b00};
  localparam logic [31:0] A_ALIAS = 32'h8000_0000 | A_DATA;

  logic           aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic           arvalid, arready, rvalid, rready, sw_stby, hw_stby, irq_n;
  logic [31:0]    awaddr, araddr, wdata, rdata;
  logic [1:0]     bresp, rresp;
  logic [2:0]     pin_in, pin_out, pin_oe, ext;
  serial_ctrl_t   sctl;
  serial_return_t sret;
  int             bad_count, tests_run;

  three_bit_shared_io_port dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .sw_standby(sw_stby), .hw_standby(hw_stby), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .serial_ctrl(sctl), .serial_ret(sret),
    .external_interrupt_line_four_n(irq_n));
  board_pin_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

  always #12.5 aclk = ~aclk;

  // ==========================================================================
  // Bus and compare helpers
  // ==========================================================================
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Ready is registered, so its level at the falling edge decides the next rising edge
  task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    bready <= 1'b1;
    while (aw_p || w_p) begin
      @(negedge aclk);
      aw_p = aw_p && !awready;
      w_p = w_p && !wready;
      @(posedge aclk);
      if (!aw_p) awvalid <= 1'b0;
      if (!w_p) wvalid <= 1'b0;
    end
    @(negedge aclk);
    while (!bvalid) @(negedge aclk);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    @(negedge aclk);
    while (!arready) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (!rvalid) @(negedge aclk);
    chk("rdata", exp, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic pins(input logic [2:0] eo, input logic [2:0] eu);
    @(negedge aclk);
    chk("pin_oe", {29'h0, eo}, {29'h0, pin_oe});
    chk("pin_out", {29'h0, eu}, {29'h0, pin_out});
  endtask : pins

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    axi_rd(A_DIR, 32'hFF, RESP_OKAY);
    axi_rd(A_DATA, 32'hFB, RESP_OKAY);
    pins(3'b000, 3'b000);
  endtask : t_reset

  task automatic t_output;
    axi_wr(A_DIR, 8'h3F, RESP_OKAY);
    axi_wr(A_DATA, 8'h26, RESP_OKAY);
    pins(3'b111, 3'b010);
    axi_rd(A_DATA, 32'hE6, RESP_OKAY);
    axi_rd(A_DIR, 32'hFF, RESP_OKAY);
  endtask : t_output

  task automatic t_mixed;
    axi_wr(A_ALIAS, 8'h00, RESP_OKAY);
    axi_wr(A_DIR, 8'h04, RESP_OKAY);
    pins(3'b010, 3'b000);
    axi_rd(A_DATA, 32'hFB, RESP_OKAY);
  endtask : t_mixed

  task automatic t_unmapped;
    axi_wr(A_HOLE, 8'h55, RESP_DECERR);
    axi_rd(A_HOLE, 32'h0, RESP_DECERR);
  endtask : t_unmapped

  task automatic t_sw_standby;
    axi_wr(A_DIR, 8'h15, RESP_OKAY);
    axi_wr(A_DATA, 8'h15, RESP_OKAY);
    @(posedge aclk);
    sw_stby <= 1'b1;
    axi_wr(A_DATA, 8'h00, RESP_OKAY);
    pins(3'b111, 3'b111);
    @(posedge aclk);
    sw_stby <= 1'b0;
    axi_rd(A_DATA, 32'hFF, RESP_OKAY);
  endtask : t_sw_standby

  task automatic t_hw_standby;
    @(posedge aclk);
    hw_stby <= 1'b1;
    repeat (4) @(posedge aclk);
    pins(3'b000, 3'b000);
    @(posedge aclk);
    hw_stby <= 1'b0;
    axi_rd(A_DATA, 32'hFB, RESP_OKAY);
  endtask : t_hw_standby

  task automatic t_serial;
    @(posedge aclk);
    sctl <= 6'b111110;
    repeat (2) @(posedge aclk);
    pins(3'b101, 3'b101);
    @(posedge aclk);
    sctl <= 6'b000001;
    ext <= 3'b010;
    repeat (3) @(posedge aclk);
    pins(3'b000, 3'b000);
    chk("irq_n", 32'h0, {31'h0, irq_n});
    chk("serial_ret", 32'h2, {30'h0, sret});
    @(posedge aclk);
    sctl <= 6'b000000;
  endtask : t_serial

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sw_stby, hw_stby} = 9'h0;
    {awaddr, araddr, wdata} = 96'h0;
    ext = 3'b101;
    sctl = 6'b000000;
    bad_count = 0;
    tests_run = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_output();
    t_mixed();
    t_unmapped();
    t_sw_standby();
    t_hw_standby();
    t_serial();
    stop_test();
  end

  // Whole run needs well under 1000 cycles; this allows twenty times that
  initial begin
    #500000;
    bad_count++;
    stop_test();
  end
endmodule : three_bit_shared_io_port_test
